// >>> src/bridge_fault_slew.sv
// Bridge control: slew select, deglitch, dead time, sleep and fault protection
// Function
// - Register slew code 000 to 111 picks fastest to slowest of eight rates.
// - Strap: grounded pin fastest, open pin middle, tied to logic supply slowest.
// - Strap resistor classes map to the intermediate rate codes.
// - Turn off conducting transistor, wait dead time, then turn on the other.
// - Inputs deglitched; filter delay grows with slower slew code.
// - Fault output pulled low while a reported fault is present.
// - Fault output low after power-up or wake until core is ready.
// - Sleep while wake control low, run when it goes high.
// - No serial reads during sleep pulse; prefer the clear-faults bit.
// - Supply undervoltage: outputs and pump off, fault low, flags latched; auto resume.
// - Supply undervoltage flag stays until clear-faults bit or sleep pulse.
// - Pump undervoltage: outputs off, pump on, flags latched, auto resume.
// - Pump undervoltage ignored while its check-off bit is set.
// - Filtered overcurrent disables both half bridges (only that half in independent mode), fault low, pump kept on.
// - Two-bit overcurrent policy; latched shutdown at code zero by default.
// - Latched shutdown resumes only after cause gone and a clear command.
// - Independent half mode applies the policy to each half separately.
// - Retry: outputs off, flags latched, resume after retry time and cause gone.
// - Report only: keep driving, fault low until cause gone and cleared.
// - Disabled: no protection nor report on overcurrent.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "bridge_consts.svh"
module bridge_fault_slew import bridge_pkg::*; #(
	parameter int RETRY_CYCLES = `RETRY_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Device pins and sensors
	input  wire logic [1:0]  in_ctrl,
	input  wire logic        wake_control,
	input  wire logic        supply_uv,
	input  wire logic        pump_uv,
	input  wire logic [3:0]  ocp_sense,
	input  wire logic [2:0]  slew_strap,
	// Bridge drive
	output logic [1:0]       hs_on,
	output logic [1:0]       ls_on,
	output logic             pump_enable,
	output logic [2:0]       slew_code,
	// Open-drain fault pin
	input  wire logic        fault_out_low_i,
	output logic             fault_out_low_o,
	output logic             fault_out_low_oe
);
	// ********************************
	// Timing
	// ********************************
	localparam int DGL_MIN_CYC = (`DGL_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int DGL_MAX_CYC = (`DGL_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int DGL_STEP = (DGL_MAX_CYC - DGL_MIN_CYC) / 7;
	localparam int DEAD_STEP = (`DEAD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int OCP_CYC = (`OCP_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int READY_CYC = (`READY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	state_type  q;
	state_type  d;
	logic       dis_all;
	logic       clr_ev;
	logic       suv_now;
	logic       puv_now;
	logic [1:0] half_cond;
	logic [3:0] ocp_evt;
	logic [10:0] dgl_len;
	logic [7:0] dead_len;
	logic [31:0] ctrl_rd;
	logic [31:0] stat_rd;

	always_comb begin
		d = q;
		d.s1 = {fault_out_low_i, slew_strap, ocp_sense, pump_uv, supply_uv, wake_control,
			in_ctrl};
		d.s2 = q.s1;
		d.clear_faults_bit = 1'b0;
		suv_now = q.s2[`SYN_SUV];
		puv_now = q.s2[`SYN_PUV] & !q.pump_uv_check_off;
		// Falling wake is the sleep reset pulse that also clears faults
		clr_ev = q.clear_faults_bit | (!q.s2[`SYN_WAKE] & !q.sleep);
		dgl_len = 11'(DGL_MIN_CYC + DGL_STEP * int'(q.slew_code));
		dead_len = 8'(DEAD_STEP * (int'(q.slew_code) + 1));
		dis_all = q.sleep | !q.ready | suv_now | puv_now;
		for (int h = 0; h < 2; h++) begin
			half_cond[h] = q.s2[`SYN_OCP_LSB + 2 * h] | q.s2[`SYN_OCP_LSB + 2 * h + 1];
		end
		// ********************************
		// Sleep, readiness and slew select
		// ********************************
		d.sleep = !q.s2[`SYN_WAKE];
		if (q.sleep) begin
			d.ready = 1'b0;
			d.ready_cnt = '0;
		end else if (!q.ready) begin
			d.ready_cnt = q.ready_cnt + 10'd1;
			if (q.ready_cnt == 10'(READY_CYC - 1)) begin
				d.ready = 1'b1;
				case (q.s2[`SYN_STRAP_LSB +: 3])
					3'h0: d.strap_code = 3'h0;
					3'h1: d.strap_code = 3'h1;
					3'h2: d.strap_code = 3'h2;
					3'h4: d.strap_code = 3'h5;
					3'h5: d.strap_code = 3'h7;
					default: d.strap_code = `SLEW_MIDDLE;
				endcase
			end
		end
		d.slew_code = q.strap_mode ? q.strap_code : q.slew_rate_select;
		// ********************************
		// Supply and pump undervoltage
		// ********************************
		d.supply_uv_lock = suv_now | (q.supply_uv_lock & !clr_ev);
		d.pump_uv_flag = puv_now | (q.pump_uv_flag & !clr_ev);
		// ********************************
		// Overcurrent
		// ********************************
		for (int i = 0; i < 4; i++) begin
			if (!q.s2[`SYN_OCP_LSB + i]) begin
				d.ocp_cnt[i] = '0;
			end else if (q.ocp_cnt[i] != 12'(OCP_CYC - 1)) begin
				d.ocp_cnt[i] = q.ocp_cnt[i] + 12'd1;
			end
			ocp_evt[i] = q.s2[`SYN_OCP_LSB + i] && q.ocp_cnt[i] == 12'(OCP_CYC - 1);
			if (clr_ev && !q.s2[`SYN_OCP_LSB + i]) begin
				d.fet_ocp[i] = 1'b0;
			end
		end
		for (int h = 0; h < 2; h++) begin
			if (q.half_off[h]) begin
				if (q.ocp_mode == `OCP_RETRY) begin
					if (q.retry_cnt[h] != '0) begin
						d.retry_cnt[h] = q.retry_cnt[h] - 21'd1;
					end else if (!(q.indep ? half_cond[h] : |half_cond)) begin
						d.half_off[h] = 1'b0;
					end
				end else if (clr_ev && !(q.indep ? half_cond[h] : |half_cond)) begin
					d.half_off[h] = 1'b0;
				end
			end
			if (clr_ev && !half_cond[h]) begin
				d.report[h] = 1'b0;
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (ocp_evt[i] && q.ocp_mode != `OCP_DISABLED) begin
				d.fet_ocp[i] = 1'b1;
				if (q.ocp_mode == `OCP_REPORT) begin
					d.report[i / 2] = 1'b1;
				end else begin
					// Shared mode takes both halves down
					for (int h = 0; h < 2; h++) begin
						if (h == i / 2 || !q.indep) begin
							d.half_off[h] = 1'b1;
							d.retry_cnt[h] = 21'(RETRY_CYCLES);
						end
					end
				end
			end
		end
		if (q.ocp_mode == `OCP_DISABLED) begin
			d.half_off = '0;
			d.report = '0;
		end
		d.ocp_flag = |d.fet_ocp;
		// ********************************
		// Half bridges with dead time
		// ********************************
		for (int h = 0; h < 2; h++) begin
			case (q.hb[h])
				HB_OFF: begin
					if (q.dead_cnt[h] != '0) begin
						d.dead_cnt[h] = q.dead_cnt[h] - 8'd1;
					end else if (!(dis_all | q.half_off[h])) begin
						d.hb[h] = q.in_filt[h] ? HB_HIGH : HB_LOW;
					end
				end
				HB_HIGH: begin
					if (dis_all | q.half_off[h] | !q.in_filt[h]) begin
						d.hb[h] = HB_OFF;
						d.dead_cnt[h] = dead_len;
					end
				end
				default: begin
					if (dis_all | q.half_off[h] | q.in_filt[h]) begin
						d.hb[h] = HB_OFF;
						d.dead_cnt[h] = dead_len;
					end
				end
			endcase
			d.hs[h] = d.hb[h] == HB_HIGH;
			d.ls[h] = d.hb[h] == HB_LOW;
			if (q.s2[h] == q.in_filt[h]) begin
				d.dgl_cnt[h] = '0;
			end else if (q.dgl_cnt[h] >= dgl_len - 11'd1) begin
				d.in_filt[h] = q.s2[h];
				d.dgl_cnt[h] = '0;
			end else begin
				d.dgl_cnt[h] = q.dgl_cnt[h] + 11'd1;
			end
		end
		d.pump = !q.sleep & !suv_now;
		d.fault_oe = !q.ready | suv_now | puv_now | (|q.half_off) | (|q.report);
		// ********************************
		// Register bus
		// ********************************
		ctrl_rd = {23'h00_0000, q.strap_mode, q.indep, 1'b0, q.pump_uv_check_off, q.ocp_mode,
			q.slew_rate_select};
		stat_rd = {16'h0000, q.half_off, q.s2[`SYN_PIN], q.sleep, q.ready, q.slew_code,
			q.fet_ocp, q.ocp_flag, q.pump_uv_flag, q.supply_uv_lock,
			q.supply_uv_lock | q.pump_uv_flag | q.ocp_flag};
		if (s_axi_awvalid && q.awready) begin
			d.aw_full = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_full = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_full && q.w_full && !q.bvalid) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `RESP_OKAY;
			if (q.awaddr == `REG_CTRL) begin
				if (q.wstrb[0]) begin
					d.slew_rate_select = q.wdata[`CTRL_SLEW_LSB +: 3];
					d.ocp_mode = q.wdata[`CTRL_OCP_LSB +: 2];
					d.pump_uv_check_off = q.wdata[`CTRL_PUVOFF_BIT];
					d.clear_faults_bit = q.wdata[`CTRL_CLR_BIT];
					d.indep = q.wdata[`CTRL_INDEP_BIT];
				end
				if (q.wstrb[1]) begin
					d.strap_mode = q.wdata[`CTRL_STRAP_BIT];
				end
			end else if (q.awaddr != `REG_STATUS) begin
				d.bresp = `RESP_SLVERR;
			end
		end
		d.awready = !d.aw_full;
		d.wready = !d.w_full;
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = `RESP_OKAY;
			if (s_axi_araddr == `REG_CTRL) begin
				d.rdata = ctrl_rd;
			end else if (s_axi_araddr == `REG_STATUS) begin
				d.rdata = stat_rd;
			end else begin
				d.rdata = 32'h0000_0000;
				d.rresp = `RESP_SLVERR;
			end
		end
		d.arready = !d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.fault_oe <= 1'b1;
			q.sleep <= 1'b1;  // Avoids a false sleep pulse after reset
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign hs_on = q.hs;
	assign ls_on = q.ls;
	assign pump_enable = q.pump;
	assign slew_code = q.slew_code;
	assign fault_out_low_o = 1'b0;
	assign fault_out_low_oe = q.fault_oe;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_no_shoot_through: assert property (!(|(q.hs & q.ls)))
		else $error("both transistors of a half bridge on");
	a_dead_gap_low: assert property ($fell(q.hs[0]) |-> !q.ls[0] [*8])
		else $error("low side on too soon after high side off");
	a_deglitch_hold: assert property ($changed(q.in_filt[0]) |->
		$past(q.dgl_cnt[0]) >= $past(dgl_len) - 11'd1)
		else $error("filtered input changed before deglitch time");
	a_ready_fault_low: assert property (!q.ready |=> q.fault_oe)
		else $error("fault pin released before core ready");
	a_sleep_outputs_off: assert property (q.sleep |=> !(|{q.hs, q.ls, q.pump}))
		else $error("drive active during sleep");
	a_uv_latch: assert property (suv_now |=> q.supply_uv_lock & q.fault_oe & !q.pump)
		else $error("supply undervoltage not handled");
	a_uv_sticky: assert property (q.supply_uv_lock && !clr_ev |=> q.supply_uv_lock)
		else $error("undervoltage flag lost without clear");
	a_puv_ignored: assert property (q.pump_uv_check_off && !q.pump_uv_flag
		|=> !q.pump_uv_flag) else $error("pump undervoltage flagged while check is off");
	a_ocp_latched: assert property (ocp_evt[0] && q.ocp_mode == `OCP_LATCHED
		|=> q.half_off[0] && q.fet_ocp[0] ##1 q.fault_oe)
		else $error("latched overcurrent shutdown missing");
	a_clear_self: assert property (q.clear_faults_bit |=> !q.clear_faults_bit)
		else $error("clear-faults bit did not self-clear");
endmodule // bridge_fault_slew

// >>> src/bridge_consts.svh
// Offsets, field positions, mode and response codes and timing figures of the bridge controller
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH
`define CLK_PERIOD_NS   4
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define CTRL_SLEW_LSB   0
`define CTRL_OCP_LSB    3
`define CTRL_PUVOFF_BIT 5
`define CTRL_CLR_BIT    6
`define CTRL_INDEP_BIT  7
`define CTRL_STRAP_BIT  8
`define OCP_LATCHED     2'b00
`define OCP_RETRY       2'b01
`define OCP_REPORT      2'b10
`define OCP_DISABLED    2'b11
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define SYN_WAKE        2
`define SYN_SUV         3
`define SYN_PUV         4
`define SYN_OCP_LSB     5
`define SYN_STRAP_LSB   9
`define SYN_PIN         12
`define DGL_MIN_NS      1500
`define DGL_MAX_NS      4500
`define DEAD_STEP_NS    100
`define OCP_FILT_NS     3000
`define READY_NS        1000
`define RETRY_NS        4000000
`define SLEW_MIDDLE     3'h3
`endif

// >>> src/bridge_pkg.sv
// Types of the bridge fault and slew controller
package bridge_pkg;
	typedef enum logic [1:0] {HB_OFF, HB_HIGH, HB_LOW} hb_state_type;
	typedef struct packed {
		logic [12:0]          s1;
		logic [12:0]          s2;
		logic [1:0]           in_filt;
		logic [1:0][10:0]     dgl_cnt;
		hb_state_type [1:0]   hb;
		logic [1:0][7:0]      dead_cnt;
		logic [3:0][11:0]     ocp_cnt;
		logic [3:0]           fet_ocp;
		logic                 ocp_flag;
		logic [1:0]           half_off;
		logic [1:0]           report;
		logic [1:0][20:0]     retry_cnt;
		logic                 supply_uv_lock;
		logic                 pump_uv_flag;
		logic                 sleep;
		logic [9:0]           ready_cnt;
		logic                 ready;
		logic [2:0]           slew_rate_select;
		logic [1:0]           ocp_mode;
		logic                 pump_uv_check_off;
		logic                 clear_faults_bit;
		logic                 indep;
		logic                 strap_mode;
		logic [2:0]           strap_code;
		logic [2:0]           slew_code;
		logic                 aw_full;
		logic [7:0]           awaddr;
		logic                 w_full;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 awready;
		logic                 wready;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic [1:0]           hs;
		logic [1:0]           ls;
		logic                 pump;
		logic                 fault_oe;
	} state_type;
endpackage

// >>> sim/mcu_model.sv
// Controller model that drives the bridge inputs and the wake line
`timescale 1ns/1ps
module mcu_model (
	// Clock
	input  wire logic       aclk,
	// Requests from the sequence
	input  wire logic [1:0] want_in,
	input  wire logic       want_wake,
	// Pins
	output logic [1:0]      in_ctrl,
	output logic            wake_control,
	output logic            may_read
);
	initial begin
		in_ctrl = 2'h0;
		wake_control = 1'h1;
	end
	// Pins change just after a clock edge
	always @(posedge aclk) begin
		in_ctrl <= want_in;
		wake_control <= want_wake;
	end
	// Serial reads are held off while the wake line is low
	assign may_read = wake_control;
endmodule // mcu_model

// >>> sim/bridge_fault_and_slew_control_bench.sv
// Self-checking bench of the bridge fault and slew controller
`timescale 1ns/1ps
`include "bridge_consts.svh"
module bridge_fault_and_slew_control_bench import bridge_pkg::*;;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  awaddr = 0;
	logic [7:0]  araddr = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0]  wstrb = 0;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	logic [1:0]  want_in = 0;
	logic        want_wake = 1, supply_uv = 0, pump_uv = 0;
	logic [3:0]  ocp_sense = 0;
	logic [2:0]  slew_strap = 0;
	wire  [1:0]  in_ctrl, hs_on, ls_on;
	wire         wake_control, may_read, pump_enable, f_o, f_oe, f_pin;
	wire  [2:0]  slew_code;
	int          n_mismatch = 0, checked = 0, cyc = 0;
	logic [31:0] rnd = 32'h0000_0030, ctrl = 0, st;
	logic [1:0]  rs;
	localparam int RETRY = 200;
	// ****************
	// Clock, pins and design
	// ****************
	always #2 aclk = ~aclk;
	assign f_pin = f_oe ? f_o : 1'b1;
	mcu_model mcu (.aclk(aclk), .want_in(want_in), .want_wake(want_wake), .in_ctrl(in_ctrl),
		.wake_control(wake_control), .may_read(may_read));
	bridge_fault_slew #(.RETRY_CYCLES(RETRY)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.in_ctrl(in_ctrl), .wake_control(wake_control), .supply_uv(supply_uv), .pump_uv(pump_uv),
		.ocp_sense(ocp_sense), .slew_strap(slew_strap), .hs_on(hs_on), .ls_on(ls_on),
		.pump_enable(pump_enable), .slew_code(slew_code), .fault_out_low_i(f_pin),
		.fault_out_low_o(f_o), .fault_out_low_oe(f_oe));
	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [2:0] strap_map(input logic [2:0] s);
		case (s)
			3'h0, 3'h1, 3'h2: return s;
			3'h4: return 3'h5;
			3'h5: return 3'h7;
			default: return 3'h3;
		endcase
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		rs = bresp;
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		while (!may_read) @(posedge aclk);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		st = rdata;
		rs = rresp;
		rready <= 0;
	endtask
	task automatic wait_ready;
		int i;
		for (i = 0; i < 600 && f_oe !== 1'b0; i++) @(posedge aclk);
		chk("fault pin released", 0, f_oe);
		wt(4);
	endtask
	task automatic clr;
		wr(`REG_CTRL, ctrl | (32'h1 << `CTRL_CLR_BIT));
	endtask
	task automatic slp;
		want_wake <= 0;
		wt(20);
		chk("sleep drive", 0, {hs_on, ls_on});
		want_wake <= 1;
		wt(4);
		chk("not ready pin", 1, f_oe);
		wait_ready;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_mismatch++;
			final_report;
		end
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		int i, j, k, d, ov;
		logic tg;
		logic [1:0] om[5] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
		logic [3:0] os[5] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'h4};
		logic [1:0] oh[5] = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h1};
		logic oe_on[5] = '{1, 1, 0, 1, 1};
		logic oe_end[5] = '{1, 1, 0, 0, 1};
		wt(6);
		chk("reset pin", 1, f_oe);
		chk("pin drive value", 0, f_o);
		aresetn <= 1;
		wait_ready;
		rd(`REG_CTRL);
		chk("ctrl reset", 0, st);
		rd(8'h08);
		chk("unmapped resp", `RESP_SLVERR, rs);
		wr(8'h0C, 32'h0000_00ff);
		chk("unmapped write", `RESP_SLVERR, rs);
		wr(`REG_STATUS, 32'h0000_00ff);
		chk("status write", `RESP_OKAY, rs);
		rd(`REG_CTRL);
		chk("ctrl untouched", 0, st);
		for (i = 0; i < 12; i++) begin
			k = i < 8 ? i : int'(rnd[2:0]);
			rnd = xs(rnd);
			ctrl = k;
			wr(`REG_CTRL, ctrl);
			wt(2);
			chk("slew_code", k, slew_code);
			rd(`REG_STATUS);
			chk("status slew", k, st[10:8]);
		end
		for (i = 0; i < 2; i++) begin
			k = 7 - 7 * i;
			ctrl = k;
			wr(`REG_CTRL, ctrl);
			tg = ~want_in[0];
			want_in[0] <= tg;
			d = 0;
			ov = 0;
			for (j = 0; j < 3000; j++) begin
				@(posedge aclk);
				if (hs_on[0] && ls_on[0]) ov++;
				if (!hs_on[0] && !ls_on[0]) d++;
				if (tg ? hs_on[0] : ls_on[0]) break;
			end
			chk("overlap", 0, ov);
			chk("switch done", 1, j < 3000);
			chk("dead time", 1, d >= 25 * (k + 1));
			chk("filter delay", 1, j >= 375 + 107 * k);
		end
		want_in[1] <= 1;
		wt(int'(rnd[7:0]) + 10);
		want_in[1] <= 0;
		ov = 0;
		for (j = 0; j < 600; j++) begin
			@(posedge aclk);
			if (hs_on[1]) ov++;
		end
		chk("glitch", 0, ov);
		want_in <= 2'h3;
		wt(500);
		chk("drive", 3, hs_on);
		supply_uv <= 1;
		wt(8);
		chk("suv drive", 0, {hs_on, ls_on, pump_enable});
		chk("suv pin", 1, f_oe);
		supply_uv <= 0;
		wt(100);
		chk("suv resume", 3'h7, {hs_on, pump_enable});
		chk("suv pin off", 0, f_oe);
		rd(`REG_STATUS);
		chk("suv flags", 3, st[1:0]);
		chk("status state", 3'h5, st[13:11]);
		slp;
		rd(`REG_STATUS);
		chk("suv cleared", 0, st[1:0]);
		pump_uv <= 1;
		wt(8);
		chk("puv drive", 1, {hs_on, ls_on, pump_enable});
		chk("puv pin", 1, f_oe);
		pump_uv <= 0;
		wt(100);
		chk("puv resume", 3, hs_on);
		rd(`REG_STATUS);
		chk("puv flag", 5, st[2:0]);
		clr;
		rd(`REG_STATUS);
		chk("puv cleared", 0, st[2:0]);
		rd(`REG_CTRL);
		chk("clear self", ctrl, st);
		ctrl = ctrl | (32'h1 << `CTRL_PUVOFF_BIT);
		wr(`REG_CTRL, ctrl);
		pump_uv <= 1;
		wt(8);
		chk("puv off pin", 0, f_oe);
		chk("puv off drive", 3, hs_on);
		pump_uv <= 0;
		for (i = 0; i < 5; i++) begin
			ctrl = (32'(om[i]) << `CTRL_OCP_LSB) | (32'(i == 4) << `CTRL_INDEP_BIT);
			wr(`REG_CTRL, ctrl);
			ocp_sense <= os[i];
			wt(800);
			chk("ocp drive", oh[i], hs_on);
			chk("ocp pin", oe_on[i], f_oe);
			chk("ocp pump", 1, pump_enable);
			rd(`REG_STATUS);
			chk("ocp flags", i == 2 ? 0 : {os[i], 4'h9}, st[7:0]);
			chk("half shut", {~oh[i]}, st[15:14]);
			ocp_sense <= 0;
			wt(100);
			chk("ocp pin hold", oe_on[i], f_oe);
			wt(200);
			chk("ocp pin after", oe_end[i], f_oe);
			clr;
			wt(100);
			chk("ocp cleared", 3'h6, {hs_on, f_oe});
		end
		ctrl = 32'h1 << `CTRL_STRAP_BIT;
		wr(`REG_CTRL, ctrl);
		for (i = 0; i < 8; i++) begin
			slew_strap <= i;
			slp;
			chk("strap slew", strap_map(i), slew_code);
		end
		final_report;
	end
endmodule // bridge_fault_and_slew_control_bench
